// *** inc/css_consts.svh ***
// Offsets, bit positions, reset values and switch counts of the clock source select
`ifndef CSS_CONSTS_SVH
`define CSS_CONSTS_SVH
`define CSS_ADDR_W       4
`define CSS_OFF_CTRL     4'h0
`define CSS_OFF_TUNE     4'h1
`define CSS_BIT_IDLE     7
`define CSS_BIT_IFS_HI   6
`define CSS_BIT_IFS_LO   4
`define CSS_BIT_PRI_RDY  3
`define CSS_BIT_INT_STB  2
`define CSS_BIT_LFS      7
`define CSS_SCS_PRI      2'h0
`define CSS_SCS_SEC      2'h1
`define CSS_RST_SCS      2'h0
`define CSS_RST_IFS      3'h4
`define CSS_RST_IDLE     1'h0
`define CSS_RST_LFS      1'h0
`define CSS_IFS_DIRECT   3'h7
`define CSS_IFS_LOW      3'h0
`define CSS_OLD_CYC      2'h2
`define CSS_NEW_CYC      2'h3
`define CSS_LOW_DIV_EXP  4'h8
`endif

// *** inc/css_pkg.sv ***
// Types shared by the clock source select design
package css_pkg;
    typedef enum logic [1:0] {CSS_PRI, CSS_SEC, CSS_INT} css_src_e;
    typedef enum logic [1:0] {MODE_RUN, MODE_IDLE, MODE_SLEEP} css_mode_e;
    typedef enum logic [1:0] {SW_IDLE, SW_OLD, SW_NEW} css_sw_e;
endpackage

// *** testbench/testbench.sv ***
// Self-checking bench for the clock source select block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic       mclk_i                 = 1'b0;
    logic       rst_i                  = 1'b1;
    logic [3:0] addr_i                 = 4'h0;
    logic [7:0] wdata_i                = 8'h00;
    logic       wr_i                   = 1'b0;
    logic       rd_i                   = 1'b0;
    logic       pri_osc_i              = 1'b0;
    logic       sec_osc_i              = 1'b0;
    logic       fast_osc_i             = 1'b0;
    logic       slow_rc_i              = 1'b0;
    logic       pri_ready_i            = 1'b1;
    logic       fast_stable_i          = 1'b0;
    logic       secondary_osc_enable_i = 1'b0;
    logic       usb_enable_i           = 1'b0;
    logic       wdt_enable_i           = 1'b1;
    logic       sleep_exec_i           = 1'b0;
    logic       wake_i                 = 1'b0;
    logic [7:0] rdata_o;
    logic [7:0] v;
    logic       sys_clk_tick_o;
    logic       cpu_clk_tick_o;
    logic       periph_clk_tick_o;
    logic       wdt_tick_o;
    logic       pri_osc_en_o;
    logic       sec_osc_en_o;
    logic       fast_osc_en_o;
    logic       slow_rc_en_o;
    logic       usb_clk_en_o;
    logic       secondary_running_flag_o;
    int         n_mismatch             = 0;
    int         checked                = 0;
    int         cyc                    = 0;
    int         n_sys;
    int         n_cpu;
    int         n_per;
    int         n_wdt;

    css_clock_select css_clock_select_i (.mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .pri_osc_i, .sec_osc_i, .fast_osc_i, .slow_rc_i, .pri_ready_i,
        .fast_stable_i, .secondary_osc_enable_i, .usb_enable_i, .wdt_enable_i,
        .sleep_exec_i, .wake_i, .sys_clk_tick_o, .cpu_clk_tick_o, .periph_clk_tick_o,
        .wdt_tick_o, .pri_osc_en_o, .sec_osc_en_o, .fast_osc_en_o, .slow_rc_en_o,
        .usb_clk_en_o, .secondary_running_flag_o);

    // Clock and oscillators; oscillator edges fall on falling clock edges, between rising ones
    initial forever #5 mclk_i = ~mclk_i;
    initial forever #30 pri_osc_i = ~pri_osc_i;
    initial forever #50 sec_osc_i = ~sec_osc_i;
    initial forever #20 fast_osc_i = ~fast_osc_i;
    initial forever #100 slow_rc_i = ~slow_rc_i;

    task automatic print_verdict;
        $display("counts: %0d checked, %0d mismatches", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    // Tick counts drift by one with oscillator phase, so allow that much
    task automatic near(input string nm, input int seen, input int exp);
        check(nm, 32'(seen), (seen >= exp - 1 && seen <= exp + 1) ? 32'(seen) : 32'(exp));
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge mclk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i   <= 1'b0;
        @(posedge mclk_i);
        v = rdata_o;
    endtask

    task automatic count(input int n);
        n_sys = 0;
        n_cpu = 0;
        n_per = 0;
        n_wdt = 0;
        repeat (n)
        begin
            @(posedge mclk_i);
            n_sys += int'(sys_clk_tick_o);
            n_cpu += int'(cpu_clk_tick_o);
            n_per += int'(periph_clk_tick_o);
            n_wdt += int'(wdt_tick_o);
        end
    endtask

    // One-cycle pulse of the sleep instruction or of a wake event
    task automatic mode(input logic go_sleep);
        @(posedge mclk_i);
        sleep_exec_i <= go_sleep;
        wake_i       <= ~go_sleep;
        @(posedge mclk_i);
        sleep_exec_i <= 1'b0;
        wake_i       <= 1'b0;
        repeat (3) @(posedge mclk_i);
    endtask

    // Bounded wait for the secondary flag, counting ticks that leak into the pause
    task automatic wait_flag;
        int k;
        k = 0;
        n_sys = 0;
        while (secondary_running_flag_o !== 1'b1 && k < 300)
        begin
            @(posedge mclk_i);
            k++;
            if (k > 3)
                n_sys += int'(sys_clk_tick_o);
        end
        check("switch done", 32'(k < 300), 32'h1);
    endtask

    // Hang guard: the sequence needs about 10000 cycles
    always @(posedge mclk_i)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end

    initial
    begin
        repeat (6) @(posedge mclk_i);
        rst_i <= 1'b0;
        // Status pins pass two flops, so let them fill before the first read
        repeat (2) @(posedge mclk_i);
        rd(4'h0); check("ctrl reset", v, 8'h48);
        rd(4'h1); check("tune reset", v, 8'h00);
        wr(4'h5, 8'hFF);
        rd(4'h5); check("unmapped", v, 8'h00);
        wr(4'h0, 8'h4D);
        rd(4'h0); check("ro bits and refused select", v, 8'h48);
        check("sec flag", secondary_running_flag_o, 1'b0);
        check("sec osc off", sec_osc_en_o, 1'b0);
        pri_ready_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        rd(4'h0); check("primary not ready", v, 8'h40);
        pri_ready_i <= 1'b1;
        $display("test reset and access done");
        // Secondary oscillator: pause then its rate
        secondary_osc_enable_i <= 1'b1;
        wr(4'h0, 8'h41);
        wait_flag();
        check("ticks in pause", 32'(n_sys), 32'h0);
        count(500); near("secondary rate", n_sys, 50);
        rd(4'h0); check("select secondary", v & 8'hF3, 8'h41);
        check("one flag", 32'($countones({v[3:2], secondary_running_flag_o}) <= 1), 32'h1);
        $display("test secondary done");
        // Internal block: every postscaler setting, changed with no pause
        fast_stable_i <= 1'b1;
        wr(4'h0, 8'h73);
        repeat (200) @(posedge mclk_i);
        check("sec flag off", secondary_running_flag_o, 1'b0);
        for (int f = 7; f > 0; f--)
        begin
            wr(4'h0, {1'b0, f[2:0], 4'h2});
            count(512); near("internal rate", n_sys, 128 >> (7 - f));
        end
        rd(4'h0); check("internal stable", v & 8'hF7, 8'h16);
        check("one flag", 32'($countones({v[3:2], secondary_running_flag_o}) <= 1), 32'h1);
        wr(4'h1, 8'h80);
        wr(4'h0, 8'h02);
        count(2048); near("fast over 256", n_sys, 2);
        check("fast on", fast_osc_en_o, 1'b1);
        wr(4'h1, 8'h00);
        count(2048); near("slow rc rate", n_sys, 102);
        near("watchdog rate", n_wdt, 102);
        check("fast off", fast_osc_en_o, 1'b0);
        rd(4'h0); check("slow flags", v & 8'hF7, 8'h02);
        $display("test internal done");
        // Idle then Sleep from the internal source
        wr(4'h0, 8'hF2);
        mode(1'b1);
        count(100); check("idle cpu", 32'(n_cpu), 32'h0);
        near("idle periph", n_per, 25);
        check("primary off in idle", pri_osc_en_o, 1'b0);
        usb_enable_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        check("primary kept for usb", pri_osc_en_o, 1'b1);
        check("usb clock", usb_clk_en_o, 1'b1);
        mode(1'b0);
        usb_enable_i <= 1'b0;
        count(100); near("run cpu", n_cpu, 25);
        wr(4'h0, 8'h72);
        mode(1'b1);
        count(100); check("sleep ticks", 32'(n_sys), 32'h0);
        near("sleep watchdog", n_wdt, 5);
        check("sleep primary", pri_osc_en_o, 1'b0);
        check("sleep fast", fast_osc_en_o, 1'b0);
        check("sleep usb", usb_clk_en_o, 1'b0);
        check("sleep secondary", sec_osc_en_o, 1'b1);
        check("sleep slow rc", slow_rc_en_o, 1'b1);
        wdt_enable_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        check("sleep slow rc off", slow_rc_en_o, 1'b0);
        wdt_enable_i <= 1'b1;
        mode(1'b0);
        $display("test internal modes done");
        // Back to primary, then primary idle
        wr(4'h0, 8'hC0);
        repeat (200) @(posedge mclk_i);
        count(600); near("primary rate", n_sys, 100);
        mode(1'b1);
        count(120); check("primary_idle_mode cpu", 32'(n_cpu), 32'h0);
        near("primary_idle_mode periph", n_per, 20);
        check("primary_idle_mode osc", pri_osc_en_o, 1'b1);
        mode(1'b0);
        $display("test primary modes done");
        print_verdict();
    end
endmodule // testbench
`default_nettype wire

// *** verilog/css_clock_select.sv ***
// System clock source selection, glitch-free switching and power mode control
// Function
// - Select field picks internal, secondary or primary
// - Any reset clears select field to primary
// - Switch after two old, three new ticks
// - Clock pauses during switch, no runt pulses
// - Frequency field picks internal output rate
// - Reset sets frequency field to 1 MHz
// - Frequency write acts immediately on internal clock
// - Low-rate bit picks divided fast or slow
// - Slow RC always clocks watchdog
// - Primary ready flag after start-up timer
// - Internal stable flag is read-only status
// - At most one status flag set
// - Idle bit picks Idle or Sleep
// - Secondary select ignored while oscillator disabled
// - Primary runs in primary idle or USB
// - Fast oscillator off when slow RC direct
// - USB clock keeps running in Run, Idle
// - Sleep stops primary, fast and USB clocks
// - Secondary clocks device in secondary modes
// - Idle bit sampled at sleep instruction
`timescale 1ns/10ps
`default_nettype none
`include "css_consts.svh"
module css_clock_select
    import css_pkg::*;
#(
    parameter int ADDR_W = `CSS_ADDR_W
)(
    input  wire logic              mclk_i,
    input  wire logic              rst_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [7:0]        wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [7:0]        rdata_o,
    input  wire logic              pri_osc_i,
    input  wire logic              sec_osc_i,
    input  wire logic              fast_osc_i,
    input  wire logic              slow_rc_i,
    input  wire logic              pri_ready_i,
    input  wire logic              fast_stable_i,
    input  wire logic              secondary_osc_enable_i,
    input  wire logic              usb_enable_i,
    input  wire logic              wdt_enable_i,
    input  wire logic              sleep_exec_i,
    input  wire logic              wake_i,
    output logic                   sys_clk_tick_o,
    output logic                   cpu_clk_tick_o,
    output logic                   periph_clk_tick_o,
    output logic                   wdt_tick_o,
    output logic                   pri_osc_en_o,
    output logic                   sec_osc_en_o,
    output logic                   fast_osc_en_o,
    output logic                   slow_rc_en_o,
    output logic                   usb_clk_en_o,
    output logic                   secondary_running_flag_o
);
    logic [5:0] s1_q;
    logic [5:0] s2_q;
    logic [3:0] s3_q;
    logic [3:0] tick;
    logic       pri_rdy_s;
    logic       fast_stb_s;
    logic       post_tick;
    logic       int_tick;
    logic       idle_q;
    logic [2:0] ifs_q;
    logic [1:0] scs_q;
    logic [1:0] scs_d;
    logic       lfs_q;
    css_src_e   target;
    css_src_e   active_q;
    css_src_e   dest_q;
    css_sw_e    sw_q;
    logic [1:0] cnt_q;
    css_mode_e  mode_q;
    logic       old_tick;
    logic       new_tick;
    logic       sys_tick_d;
    logic       rc_direct;
    logic       pri_flag;
    logic       int_flag;
    logic       sec_flag;
    logic       wr_ctrl;
    logic       wr_tune;

    // Decodes the select field into a source
    function automatic css_src_e scs_decode(input logic [1:0] scs);
        if (scs[1])
            return CSS_INT;
        else if (scs == `CSS_SCS_SEC)
            return CSS_SEC;
        else
            return CSS_PRI;
    endfunction

    // Picks the tick stream of one source; used for old and new side
    function automatic logic src_tick(input css_src_e s, input logic [3:0] t, input logic it);
        case (s)
            CSS_PRI: return t[0];
            CSS_SEC: return t[1];
            default: return it;
        endcase
    endfunction

    // Oscillator and status pins come from outside; two flops before any use
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            s1_q <= 6'h00;
            s2_q <= 6'h00;
            s3_q <= 4'h0;
        end
        else
        begin
            s1_q <= {fast_stable_i, pri_ready_i, slow_rc_i, fast_osc_i, sec_osc_i, pri_osc_i};
            s2_q <= s1_q;
            s3_q <= s2_q[3:0];
        end
    end

    // One tick per rising edge of each oscillator; sources must run below half mclk
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_edge
            assign tick[gi] = s2_q[gi] && !s3_q[gi];
        end
    endgenerate
    assign pri_rdy_s  = s2_q[4];
    assign fast_stb_s = s2_q[5];

    css_postscaler u_post (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .tick_i (tick[2]),
        .ifs_i  (ifs_q),
        .tick_o (post_tick)
    );

    // Low setting uses slow RC directly unless the low-rate bit picks fast/256
    assign rc_direct = (ifs_q == `CSS_IFS_LOW) && !lfs_q;
    assign int_tick  = rc_direct ? tick[3] : post_tick;

    assign wr_ctrl = wr_i && (addr_i == ADDR_W'(`CSS_OFF_CTRL));
    assign wr_tune = wr_i && (addr_i == ADDR_W'(`CSS_OFF_TUNE));

    // Secondary select is dropped while its oscillator is disabled
    always_comb
    begin
        scs_d = wdata_i[1:0];
        if (wdata_i[1:0] == `CSS_SCS_SEC && !secondary_osc_enable_i)
            scs_d = scs_q;
    end

    // Control register fields
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            idle_q <= `CSS_RST_IDLE;
            ifs_q  <= `CSS_RST_IFS;
            scs_q  <= `CSS_RST_SCS;
        end
        else if (wr_ctrl)
        begin
            idle_q <= wdata_i[`CSS_BIT_IDLE];
            ifs_q  <= wdata_i[`CSS_BIT_IFS_HI:`CSS_BIT_IFS_LO];
            scs_q  <= scs_d;
        end
    end

    // Tuning register holds only the low-rate source bit here
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            lfs_q <= `CSS_RST_LFS;
        else if (wr_tune)
            lfs_q <= wdata_i[`CSS_BIT_LFS];
    end

    assign target   = scs_decode(scs_q);
    assign old_tick = src_tick(active_q, tick, int_tick);
    assign new_tick = src_tick(dest_q, tick, int_tick);

    // Switch sequencer: count old ticks, then new ticks, then hand over
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            sw_q     <= SW_IDLE;
            cnt_q    <= 2'h0;
            active_q <= CSS_PRI;
            dest_q   <= CSS_PRI;
        end
        else
        begin
            case (sw_q)
                SW_IDLE:
                    if (target != active_q)
                    begin
                        sw_q   <= SW_OLD;
                        dest_q <= target;
                        cnt_q  <= 2'h0;
                    end
                SW_OLD:
                    if (old_tick)
                    begin
                        if (cnt_q == `CSS_OLD_CYC - 2'h1)
                        begin
                            sw_q  <= SW_NEW;
                            cnt_q <= 2'h0;
                        end
                        else
                            cnt_q <= cnt_q + 2'h1;
                    end
                SW_NEW:
                    if (new_tick)
                    begin
                        if (cnt_q == `CSS_NEW_CYC - 2'h1)
                        begin
                            sw_q     <= SW_IDLE;
                            active_q <= dest_q;
                        end
                        else
                            cnt_q <= cnt_q + 2'h1;
                    end
                default:
                    sw_q <= SW_IDLE;
            endcase
        end
    end

    // Power mode; the idle bit is taken as it stands at the sleep instruction
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            mode_q <= MODE_RUN;
        else if (mode_q == MODE_RUN && sleep_exec_i)
            mode_q <= idle_q ? MODE_IDLE : MODE_SLEEP;
        else if (wake_i)
            mode_q <= MODE_RUN;
    end

    // Whole ticks pass only outside a switch, so no clock is ever cut short
    assign sys_tick_d = (sw_q == SW_IDLE) && (mode_q != MODE_SLEEP) && old_tick;

    // Status flags keyed to the running source, so only one can be set
    assign pri_flag = (active_q == CSS_PRI) && pri_rdy_s;
    assign int_flag = (active_q == CSS_INT) && fast_stb_s && !rc_direct;
    assign sec_flag = (active_q == CSS_SEC) && (sw_q == SW_IDLE);

    // Clock tick outputs, all registered
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            sys_clk_tick_o    <= 1'b0;
            cpu_clk_tick_o    <= 1'b0;
            periph_clk_tick_o <= 1'b0;
            wdt_tick_o        <= 1'b0;
        end
        else
        begin
            sys_clk_tick_o    <= sys_tick_d;
            cpu_clk_tick_o    <= sys_tick_d && (mode_q == MODE_RUN);
            periph_clk_tick_o <= sys_tick_d;
            wdt_tick_o        <= tick[3];
        end
    end

    // Oscillator enables; secondary may stay on for its timers in any mode
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            pri_osc_en_o <= 1'b1;
            sec_osc_en_o <= 1'b0;
            fast_osc_en_o <= 1'b0;
            slow_rc_en_o <= 1'b1;
            usb_clk_en_o <= 1'b0;
            secondary_running_flag_o <= 1'b0;
        end
        else
        begin
            pri_osc_en_o <= (mode_q != MODE_SLEEP) && (usb_enable_i ||
                ((mode_q == MODE_RUN || active_q == CSS_PRI) &&
                 (active_q == CSS_PRI || dest_q == CSS_PRI)));
            sec_osc_en_o <= secondary_osc_enable_i;
            fast_osc_en_o <= (mode_q != MODE_SLEEP) && !rc_direct &&
                (active_q == CSS_INT || dest_q == CSS_INT);
            slow_rc_en_o <= (mode_q != MODE_SLEEP) || wdt_enable_i;
            usb_clk_en_o <= usb_enable_i && (mode_q != MODE_SLEEP);
            secondary_running_flag_o <= sec_flag;
        end
    end

    // Read data stand one cycle after the strobe; unmapped addresses read zero
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            rdata_o <= 8'h00;
        else if (rd_i && addr_i == ADDR_W'(`CSS_OFF_CTRL))
            rdata_o <= {idle_q, ifs_q, pri_flag, int_flag, scs_q};
        else if (rd_i && addr_i == ADDR_W'(`CSS_OFF_TUNE))
            rdata_o <= {lfs_q, 7'h00};
        else
            rdata_o <= 8'h00;
    end

    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    sequence s_old_done;
        sw_q == SW_OLD && old_tick && cnt_q == 2'h1;
    endsequence

    sequence s_new_done;
        sw_q == SW_NEW && new_tick && cnt_q == 2'h2;
    endsequence

    a_reset_fields: assert property (disable iff (1'b0) rst_i |=>
        scs_q == 2'h0 && ifs_q == 3'h4 && active_q == CSS_PRI)
        else $error("reset values wrong");
    a_sec_ignored: assert property (wr_ctrl && wdata_i[1:0] == 2'h1 &&
        !secondary_osc_enable_i |=> scs_q == $past(scs_q))
        else $error("secondary select not ignored");
    a_old_to_new: assert property (s_old_done |=> sw_q == SW_NEW && cnt_q == 2'h0)
        else $error("old side count wrong");
    a_new_handover: assert property (s_new_done |=>
        sw_q == SW_IDLE && active_q == $past(dest_q))
        else $error("handover wrong");
    a_pause_gap: assert property (sw_q != SW_IDLE |=> !sys_clk_tick_o)
        else $error("tick during switch");
    a_sleep_entry: assert property (mode_q == MODE_RUN && sleep_exec_i |=>
        mode_q == ($past(idle_q) ? MODE_IDLE : MODE_SLEEP))
        else $error("wrong power mode");
    a_sleep_stops: assert property (mode_q == MODE_SLEEP |=>
        !pri_osc_en_o && !fast_osc_en_o && !sys_clk_tick_o)
        else $error("clock running in sleep");
    a_flags_onehot: assert property ($onehot0({pri_flag, int_flag, sec_flag}))
        else $error("several status flags");
    a_fast_off_rc: assert property (rc_direct |=> !fast_osc_en_o)
        else $error("fast oscillator left on");
    a_primary_idle_mode: assert property (mode_q == MODE_IDLE && active_q == CSS_PRI |=>
        pri_osc_en_o)
        else $error("primary stopped in primary idle");
    a_wdt_tick: assert property (tick[3] |=> wdt_tick_o)
        else $error("watchdog tick lost");
endmodule // css_clock_select
`default_nettype wire

// *** verilog/css_postscaler.sv ***
// Divides fast internal oscillator ticks by the power of two the frequency field picks
`timescale 1ns/10ps
`default_nettype none
`include "css_consts.svh"
module css_postscaler
    import css_pkg::*;
#(
    parameter int CNT_W = 8
)(
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    input  wire logic       tick_i,
    input  wire logic [2:0] ifs_i,
    output logic            tick_o
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] mask;
    logic [3:0]       dexp;

    // 111 passes ticks through, each step down to 001 halves, 000 divides by 256
    always_comb
    begin
        dexp = (ifs_i == `CSS_IFS_LOW) ? `CSS_LOW_DIV_EXP : (4'h7 - {1'b0, ifs_i});
        mask = CNT_W'((9'h001 << dexp) - 9'h001);
    end

    // Free running count; selection changes act on the next tick, no pause
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            cnt_q <= '0;
        else if (tick_i)
            cnt_q <= cnt_q + 1'b1;
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            tick_o <= 1'b0;
        else
            tick_o <= tick_i && ((cnt_q & mask) == mask);
    end
endmodule // css_postscaler
`default_nettype wire
